// file: hdl/i2c_slave_map.svh
`ifndef I2C_SLAVE_MAP_SVH
`define I2C_SLAVE_MAP_SVH
// ***************
// timing
// ***************
`define SYS_CLK_HZ      10000000
`define ADC_CONV_NS     18000
`define DISP_REFRESH_US 10000
`define STRETCH_CYC     4'h2
// ***************
// register map
// ***************
`define REG_CTRL   8'h00
`define REG_STATUS 8'h04
`define REG_FLAGS  8'h08
`define CTRL_RESET 32'h001E0003
`define CB_SEL_RISE 0
`define CB_SEL_FALL 1
`define CB_SCL_MASK 2
`define CB_SDA_MASK 3
`define CB_ACK_LSB  16
`define FB_DONE    0
`define FB_STOP    1
`define FB_SCL_REQ 2
`define FB_SDA_REQ 3
`define RESP_OKAY   2'h0
`define RESP_SLVERR 2'h2
// ***************
// slave addresses and ids
// ***************
`define SADR_DISP_ADC 7'h30
`define SADR_RAM      7'h38
`define SADR_SPARE3   7'h40
`define SADR_SPARE4   7'h48
`define ID_NONE     4'h0
`define ID_DISP_ADC 4'h1
`define ID_RAM      4'h2
`define ID_SPARE3   4'h3
`define ID_SPARE4   4'h4
`define IDLE_BYTE   8'hFF
`define AVG_SHIFT   4
`endif

// file: hdl/i2c_slave_pkg.sv
`include "i2c_slave_map.svh"
package i2c_slave_pkg;
   typedef enum logic [2:0] {
      ST_IDLE = 3'h0, ST_ADDR = 3'h1, ST_ADDR_ACK = 3'h3, ST_RX = 3'h2,
      ST_RX_ACK = 3'h6, ST_TX = 3'h7, ST_TX_ACK = 3'h5, ST_SKIP = 3'h4
   } bus_state_t;

   typedef struct packed {
      logic [7:0]         cyc;
      logic [1:0]         chan;
      logic               start;
      logic [3:0]         idx;
      logic [63:0][11:0]  samples;
      logic [3:0][15:0]   sum;
      logic [3:0][11:0]   avg;
   } adc_state_t;

   typedef struct packed {
      logic               scl_meta, scl_sync, scl_prev;
      logic               sda_meta, sda_sync, sda_prev;
      logic               sw_meta, sw_sync;
      bus_state_t         st;
      logic [3:0]         bitcnt;
      logic [7:0]         shift;
      logic               rw;
      logic [3:0]         id;
      logic               first;
      logic [3:0]         stretch;
      logic               scl_oe, sda_oe, scl_out, sda_out;
      logic               trc, ackd, std, spd;
      logic [7:0]         rx_data;
      logic               done_flag, stop_flag, scl_req, sda_req;
      logic [31:0]        ctrl;
      logic [6:0]         ram_ptr;
      logic [127:0][7:0]  ram;
      logic               disp_ptr;
      logic [1:0][7:0]    disp_pend;
      logic [1:0][7:0]    disp;
      logic               dirty;
      logic [2:0]         adc_ptr;
      logic [19:0]        refresh_cnt;
      logic               upper;
      logic [3:0]         led;
      logic               awready, wready, bvalid, arready, rvalid;
      logic [1:0]         bresp, rresp;
      logic [31:0]        rdata;
   } slave_state_t;
endpackage : i2c_slave_pkg

// file: hdl/adc_average.sv
`timescale 1ns/1ns
`include "i2c_slave_map.svh"
module adc_average #(
   parameter int CONV_CYC = (`ADC_CONV_NS * (`SYS_CLK_HZ / 1000000)) / 1000
) (
   input  wire logic        sys_clk,
   input  wire logic        reset,
   output logic             adc_convert_start,
   output logic [1:0]       adc_channel,
   input  wire logic        adc_result_valid,
   input  wire logic [11:0] adc_result,
   output logic [47:0]      avg_out
);
   i2c_slave_pkg::adc_state_t s, n;
   logic [5:0]              slot;

   assign slot = {s.chan, s.idx};

   // scan pacing, sample ring and running sums
   always_comb begin
      n = s;
      n.start = 1'b0;
      if (s.cyc == 8'(CONV_CYC - 1)) begin
         n.cyc = 8'h00;
         n.start = 1'b1;
      end else begin
         n.cyc = s.cyc + 8'h01;
      end
      if (adc_result_valid) begin
         n.samples[slot] = adc_result;
         n.sum[s.chan] = s.sum[s.chan] - 16'(s.samples[slot]) + 16'(adc_result);
         n.chan = s.chan + 2'h1;
         if (s.chan == 2'h3) begin
            n.idx = s.idx + 4'h1;
            // averages only move once the whole scan is in, so the four agree
            for (int c = 0; c < 4; c++) begin
               n.avg[c] = 12'(n.sum[c] >> `AVG_SHIFT);
            end
         end
      end
   end

   always_ff @(posedge sys_clk) begin
      if (reset) begin
         s <= '0;
      end else begin
         s <= n;
      end
   end

   assign adc_convert_start = s.start;
   assign adc_channel       = s.chan;
   assign avg_out           = s.avg;

   property p_scan_wrap;
      @(posedge sys_clk) disable iff (reset)
      adc_result_valid && s.chan == 2'h3 |=> s.chan == 2'h0;
   endproperty
   a_scan_wrap: assert property (p_scan_wrap) else $error("scan did not wrap");

   property p_avg_moves;
      @(posedge sys_clk) disable iff (reset)
      $changed(s.avg) |-> $past(adc_result_valid) && $past(s.chan) == 2'h3;
   endproperty
   a_avg_moves: assert property (p_avg_moves) else $error("average moved mid scan");
endmodule : adc_average

// file: hdl/multi_function_i2c_slave.sv
`timescale 1ns/1ns
`include "i2c_slave_map.svh"
module multi_function_i2c_slave #(
   parameter int HALF_CYC = `DISP_REFRESH_US * (`SYS_CLK_HZ / 1000000) / 2
) (
   input  wire logic        sys_clk,
   input  wire logic        reset,
   input  wire logic        scl_in,
   output logic             scl_out,
   output logic             scl_oe,
   input  wire logic        sda_in,
   output logic             sda_out,
   output logic             sda_oe,
   input  wire logic        display_select_switch,
   output logic [3:0]       led_nibble,
   output logic             led_upper_half,
   output logic             adc_convert_start,
   output logic [1:0]       adc_channel,
   input  wire logic        adc_result_valid,
   input  wire logic [11:0] adc_result,
   input  wire logic        awvalid,
   output logic             awready,
   input  wire logic [7:0]  awaddr,
   input  wire logic        wvalid,
   output logic             wready,
   input  wire logic [31:0] wdata,
   input  wire logic [3:0]  wstrb,
   output logic             bvalid,
   input  wire logic        bready,
   output logic [1:0]       bresp,
   input  wire logic        arvalid,
   output logic             arready,
   input  wire logic [7:0]  araddr,
   output logic             rvalid,
   input  wire logic        rready,
   output logic [31:0]      rdata,
   output logic [1:0]       rresp
);
   i2c_slave_pkg::slave_state_t s, n;
   logic        scl_rise, scl_fall;
   logic        scl_edge_interrupt, sda_edge_interrupt;
   logic        scl_act_rise, scl_act_fall;
   logic        start_ev, stop_ev;
   logic        ram_step;
   logic [7:0]  tx_byte;
   logic [47:0] avg_bus;
   logic [11:0] avg_sel;

   function automatic logic [3:0] addr_id(input logic [6:0] a);
      case (a)
         `SADR_DISP_ADC: addr_id = `ID_DISP_ADC;
         `SADR_RAM:      addr_id = `ID_RAM;
         `SADR_SPARE3:   addr_id = `ID_SPARE3;
         `SADR_SPARE4:   addr_id = `ID_SPARE4;
         default:        addr_id = `ID_NONE;
      endcase
   endfunction : addr_id

   adc_average u_adc (
      .sys_clk           (sys_clk),
      .reset             (reset),
      .adc_convert_start (adc_convert_start),
      .adc_channel       (adc_channel),
      .adc_result_valid  (adc_result_valid),
      .adc_result        (adc_result),
      .avg_out           (avg_bus)
   );

   // ***************
   // bus edge detection
   // ***************
   // edges read only the second and third stages, never the metastable first
   assign scl_rise = s.scl_sync & ~s.scl_prev;
   assign scl_fall = ~s.scl_sync & s.scl_prev;
   assign scl_edge_interrupt = (scl_rise & s.ctrl[`CB_SEL_RISE])
                             | (scl_fall & s.ctrl[`CB_SEL_FALL]);
   assign sda_edge_interrupt = s.sda_sync ^ s.sda_prev;
   assign scl_act_rise = scl_rise & s.ctrl[`CB_SEL_RISE] & ~s.ctrl[`CB_SCL_MASK];
   assign scl_act_fall = scl_fall & s.ctrl[`CB_SEL_FALL] & ~s.ctrl[`CB_SCL_MASK];
   assign start_ev = sda_edge_interrupt & ~s.sda_sync & s.scl_sync & s.scl_prev
                   & ~s.ctrl[`CB_SDA_MASK];
   assign stop_ev  = sda_edge_interrupt & s.sda_sync & s.scl_sync & s.scl_prev
                   & ~s.ctrl[`CB_SDA_MASK];

   // channel then upper nibble, lower byte
   assign avg_sel = avg_bus[12 * s.adc_ptr[2:1] +: 12];
   always_comb begin
      case (s.id)
         `ID_DISP_ADC: tx_byte = s.adc_ptr[0] ? avg_sel[7:0] : {4'h0, avg_sel[11:8]};
         `ID_RAM:      tx_byte = s.ram[s.ram_ptr];
         default:      tx_byte = `IDLE_BYTE;
      endcase
   end

   // ***************
   // next state
   // ***************
   always_comb begin
      n = s;
      ram_step = 1'b0;
      n.scl_meta = scl_in;
      n.scl_sync = s.scl_meta;
      n.scl_prev = s.scl_sync;
      n.sda_meta = sda_in;
      n.sda_sync = s.sda_meta;
      n.sda_prev = s.sda_sync;
      n.sw_meta  = display_select_switch;
      n.sw_sync  = s.sw_meta;
      n.awready  = 1'b0;
      n.wready   = 1'b0;
      n.arready  = 1'b0;
      n.scl_out  = 1'b0;
      n.sda_out  = 1'b0;

      // register writes come first so that a same-cycle hardware set wins
      if (s.bvalid && bready) n.bvalid = 1'b0;
      if (awvalid && wvalid && !s.awready && !s.bvalid) begin
         n.awready = 1'b1;
         n.wready  = 1'b1;
      end
      if (s.awready && awvalid && wvalid) begin
         n.bvalid = 1'b1;
         n.bresp  = `RESP_OKAY;
         case (awaddr)
            `REG_CTRL: begin
               for (int b = 0; b < 4; b++) begin
                  if (wstrb[b]) n.ctrl[8 * b +: 8] = wdata[8 * b +: 8];
               end
            end
            `REG_FLAGS: begin
               if (wstrb[0]) begin
                  if (wdata[`FB_DONE])    n.done_flag = 1'b0;
                  if (wdata[`FB_STOP])    n.stop_flag = 1'b0;
                  if (wdata[`FB_SCL_REQ]) n.scl_req   = 1'b0;
                  if (wdata[`FB_SDA_REQ]) n.sda_req   = 1'b0;
               end
            end
            default: n.bresp = `RESP_SLVERR;
         endcase
      end
      if (s.rvalid && rready) n.rvalid = 1'b0;
      if (arvalid && !s.arready && !s.rvalid) n.arready = 1'b1;
      if (s.arready && arvalid) begin
         n.rvalid = 1'b1;
         n.rresp  = `RESP_OKAY;
         case (araddr)
            `REG_CTRL:   n.rdata = s.ctrl;
            `REG_STATUS: n.rdata = {13'h0000, s.st, s.rx_data, s.id, s.trc, s.ackd, s.std, s.spd};
            `REG_FLAGS:  n.rdata = {28'h0000000, s.sda_req, s.scl_req, s.stop_flag, s.done_flag};
            default: begin
               n.rdata = 32'h00000000;
               n.rresp = `RESP_SLVERR;
            end
         endcase
      end

      if (scl_edge_interrupt && s.ctrl[`CB_SCL_MASK]) n.scl_req = 1'b1;
      if (sda_edge_interrupt && s.ctrl[`CB_SDA_MASK]) n.sda_req = 1'b1;

      if (s.stretch != 4'h0) begin
         n.stretch = s.stretch - 4'h1;
         n.scl_oe  = s.stretch > 4'h1;
      end

      // bus edges handled the same cycle they are seen
      if (stop_ev) begin
         // back to idle, both lines released
         n.st = i2c_slave_pkg::ST_IDLE;
         n.sda_oe = 1'b0;
         n.scl_oe = 1'b0;
         n.stretch = 4'h0;
         n.spd = 1'b1;
         n.std = 1'b0;
         n.stop_flag = 1'b1;
         if (s.dirty) begin
            n.disp  = s.disp_pend;
            n.dirty = 1'b0;
         end
      end else if (start_ev) begin
         n.st = i2c_slave_pkg::ST_ADDR;
         n.bitcnt = 4'h0;
         n.sda_oe = 1'b0;
         n.std = 1'b1;
         n.spd = 1'b0;
      end else if (scl_act_rise) begin
         unique case (s.st)
            i2c_slave_pkg::ST_ADDR, i2c_slave_pkg::ST_RX: begin
               n.shift  = {s.shift[6:0], s.sda_sync};
               n.bitcnt = s.bitcnt + 4'h1;
            end
            i2c_slave_pkg::ST_TX_ACK: begin
               n.ackd = ~s.sda_sync;
               if (s.sda_sync) n.st = i2c_slave_pkg::ST_SKIP;
            end
            i2c_slave_pkg::ST_SKIP: n.bitcnt = (s.bitcnt == 4'h8) ? 4'h0 : s.bitcnt + 4'h1;
            i2c_slave_pkg::ST_IDLE, i2c_slave_pkg::ST_ADDR_ACK,
            i2c_slave_pkg::ST_RX_ACK, i2c_slave_pkg::ST_TX: ;
         endcase
      end else if (scl_act_fall) begin
         unique case (s.st)
            i2c_slave_pkg::ST_ADDR: begin
               if (s.bitcnt == 4'h8) begin
                  n.id = addr_id(s.shift[7:1]);
                  n.rw = s.shift[0];
                  n.trc = s.shift[0];
                  n.bitcnt = 4'h0;
                  if (n.id != `ID_NONE && s.ctrl[`CB_ACK_LSB + n.id]) begin
                     n.sda_oe = 1'b1;
                     n.first = 1'b1;
                     n.st = i2c_slave_pkg::ST_ADDR_ACK;
                  end else begin
                     n.id = `ID_NONE;
                     n.st = i2c_slave_pkg::ST_SKIP;
                  end
               end
            end
            i2c_slave_pkg::ST_ADDR_ACK, i2c_slave_pkg::ST_TX_ACK: begin
               n.bitcnt = 4'h0;
               if (s.rw) begin
                  n.shift = tx_byte;
                  n.sda_oe = ~tx_byte[7];
                  n.st = i2c_slave_pkg::ST_TX;
                  if (s.id == `ID_RAM) ram_step = 1'b1;
                  // pointer wraps after channel 3 low byte
                  if (s.id == `ID_DISP_ADC) n.adc_ptr = s.adc_ptr + 3'h1;
               end else begin
                  n.sda_oe = 1'b0;
                  n.st = i2c_slave_pkg::ST_RX;
               end
            end
            i2c_slave_pkg::ST_RX: begin
               if (s.bitcnt == 4'h8) begin
                  n.done_flag = 1'b1;
                  n.rx_data = s.shift;
                  n.sda_oe = 1'b1;
                  n.scl_oe = 1'b1;
                  n.stretch = `STRETCH_CYC;
                  n.st = i2c_slave_pkg::ST_RX_ACK;
                  if (s.first) begin
                     n.first = 1'b0;
                     if (s.id == `ID_RAM) n.ram_ptr = s.shift[6:0];
                     if (s.id == `ID_DISP_ADC) n.disp_ptr = s.shift[0];
                  end else if (s.id == `ID_RAM) begin
                     n.ram[s.ram_ptr] = s.shift;
                     ram_step = 1'b1;
                  end else if (s.id == `ID_DISP_ADC) begin
                     n.disp_pend[s.disp_ptr] = s.shift;
                     n.disp_ptr = ~s.disp_ptr;
                     n.dirty = 1'b1;
                  end
               end
            end
            i2c_slave_pkg::ST_RX_ACK: begin
               n.sda_oe = 1'b0;
               n.bitcnt = 4'h0;
               n.st = i2c_slave_pkg::ST_RX;
            end
            i2c_slave_pkg::ST_TX: begin
               if (s.bitcnt == 4'h7) begin
                  n.sda_oe = 1'b0;
                  n.st = i2c_slave_pkg::ST_TX_ACK;
               end else begin
                  n.shift = {s.shift[6:0], 1'b0};
                  n.sda_oe = ~s.shift[6];
                  n.bitcnt = s.bitcnt + 4'h1;
               end
            end
            i2c_slave_pkg::ST_IDLE, i2c_slave_pkg::ST_SKIP: ;
         endcase
      end
      if (ram_step) n.ram_ptr = s.ram_ptr + 7'h01;

      if (s.refresh_cnt == 20'(HALF_CYC - 1)) begin
         n.refresh_cnt = 20'h00000;
         n.upper = ~s.upper;
         n.led = s.upper ? s.disp[s.sw_sync][3:0] : s.disp[s.sw_sync][7:4];
      end else begin
         n.refresh_cnt = s.refresh_cnt + 20'h00001;
      end
   end

   always_ff @(posedge sys_clk) begin
      if (reset) begin
         s <= '0;
         s.ctrl <= `CTRL_RESET;
         s.scl_meta <= 1'b1;
         s.scl_sync <= 1'b1;
         s.scl_prev <= 1'b1;
         s.sda_meta <= 1'b1;
         s.sda_sync <= 1'b1;
         s.sda_prev <= 1'b1;
      end else begin
         s <= n;
      end
   end

   assign scl_out = s.scl_out;
   assign scl_oe = s.scl_oe;
   assign sda_out = s.sda_out;
   assign sda_oe = s.sda_oe;
   assign led_nibble = s.led;
   assign led_upper_half = s.upper;
   assign awready = s.awready;
   assign wready = s.wready;
   assign bvalid = s.bvalid;
   assign bresp = s.bresp;
   assign arready = s.arready;
   assign rvalid = s.rvalid;
   assign rdata = s.rdata;
   assign rresp = s.rresp;

   // ***************
   // checks
   // ***************
   property p_open_drain;
      @(posedge sys_clk) disable iff (reset) !scl_out && !sda_out;
   endproperty
   a_open_drain: assert property (p_open_drain) else $error("pin latch left high");

   property p_skip_quiet;
      @(posedge sys_clk) disable iff (reset)
      s.st == i2c_slave_pkg::ST_SKIP |-> !sda_oe && !scl_oe && (s.id == `ID_NONE || s.rw);
   endproperty
   a_skip_quiet: assert property (p_skip_quiet) else $error("drove sda while skipping");

   property p_done_flag;
      @(posedge sys_clk) disable iff (reset)
      scl_act_fall && s.st == i2c_slave_pkg::ST_RX && s.bitcnt == 4'h8 && !stop_ev && !start_ev
      |=> s.done_flag && sda_oe && s.rx_data == $past(s.shift);
   endproperty
   a_done_flag: assert property (p_done_flag) else $error("byte end not flagged");

   property p_stop_idle;
      @(posedge sys_clk) disable iff (reset)
      stop_ev |=> s.st == i2c_slave_pkg::ST_IDLE && !sda_oe && !scl_oe && s.spd;
   endproperty
   a_stop_idle: assert property (p_stop_idle) else $error("stop did not release");

   property p_commit;
      @(posedge sys_clk) disable iff (reset) $changed(s.disp) |-> $past(stop_ev);
   endproperty
   a_commit: assert property (p_commit) else $error("display changed without stop");

   property p_ram_wrap;
      @(posedge sys_clk) disable iff (reset)
      ram_step && s.ram_ptr == 7'h7F |=> s.ram_ptr == 7'h00;
   endproperty
   a_ram_wrap: assert property (p_ram_wrap) else $error("storage pointer no wrap");

   property p_nack;
      @(posedge sys_clk) disable iff (reset)
      scl_act_rise && s.st == i2c_slave_pkg::ST_TX_ACK && s.sda_sync && !stop_ev && !start_ev
      |=> s.st == i2c_slave_pkg::ST_SKIP ##1 !sda_oe;
   endproperty
   a_nack: assert property (p_nack) else $error("nack did not end send");

   property p_edge_off;
      @(posedge sys_clk) disable iff (reset)
      !s.ctrl[`CB_SEL_RISE] && !s.ctrl[`CB_SEL_FALL] && !start_ev && !stop_ev
      |=> s.bitcnt == $past(s.bitcnt);
   endproperty
   a_edge_off: assert property (p_edge_off) else $error("edge seen while disabled");

   property p_stretch;
      @(posedge sys_clk) disable iff (reset) $rose(scl_oe) |-> ##[1:3] !scl_oe;
   endproperty
   a_stretch: assert property (p_stretch) else $error("clock held too long");

   property p_start_status;
      @(posedge sys_clk) disable iff (reset)
      start_ev && !stop_ev |=> s.std && !s.spd && s.st == i2c_slave_pkg::ST_ADDR;
   endproperty
   a_start_status: assert property (p_start_status) else $error("start not recorded");
endmodule : multi_function_i2c_slave

// file: verif/i2c_master_model.sv
`timescale 1ns/1ns
module i2c_master_model (
   input  wire logic scl,
   input  wire logic sda,
   output logic      scl_lo,
   output logic      sda_lo
);
   // both lines released while idle, the link clock stands still
   initial begin
      scl_lo = 1'b0;
      sda_lo = 1'b0;
   end
   // honour stretch: the high phase starts when the wired line rises
   // a stretch ends on a system clock edge, so step off that edge before timing on
   task bit_x(input logic v, output logic s);
      #100 sda_lo = !v;
      #300 scl_lo = 1'b0;
      #1;
      if (scl !== 1'b1) begin
         wait (scl === 1'b1);
         #36;
      end
      #349 s = sda;
      #50 scl_lo = 1'b1;
   endtask : bit_x
   // the odd offset keeps our edges off the system clock edges
   task start;
      #137 sda_lo = 1'b0;
      #300 scl_lo = 1'b0;
      wait (scl === 1'b1);
      #400 sda_lo = 1'b1;
      #400 scl_lo = 1'b1;
   endtask : start
   // odd offset again: a caller may arrive right on a system clock edge
   task stop;
      #137 sda_lo = 1'b1;
      #263 scl_lo = 1'b0;
      wait (scl === 1'b1);
      #400 sda_lo = 1'b0;
      #400;
   endtask : stop
   // bytes go out msb first, as the slave expects
   task send(input logic [7:0] v, output logic a);
      logic s;
      for (int i = 7; i >= 0; i--) bit_x(v[i], s);
      bit_x(1'b1, s);
      a = !s;
   endtask : send
   // a nack ends the read, the caller then stops
   task recv(input logic a, output logic [7:0] v);
      logic s;
      for (int i = 7; i >= 0; i--) bit_x(1'b1, v[i]);
      bit_x(!a, s);
   endtask : recv
endmodule : i2c_master_model

// file: verif/tb.sv
`timescale 1ns/1ns
`include "i2c_slave_map.svh"
`define CHK(n, e, g) begin checked++; if ((g) !== (e)) begin failures++; \
   $display("mismatch %s expected %h seen %h", n, e, g); end end
module tb;
   logic        sys_clk = 0, reset = 1, display_select_switch = 0, adc_result_valid = 0;
   logic        awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
   logic [7:0]  awaddr = 0, araddr = 0, b;
   logic [31:0] wdata = 0, rdata, d;
   logic [11:0] adc_result = 0;
   logic [3:0]  led_nibble, wstrb = 4'hF;
   logic [1:0]  adc_channel, bresp, rresp, r;
   logic        scl_out, scl_oe, sda_out, sda_oe, led_upper_half, adc_convert_start;
   logic        awready, wready, bvalid, arready, rvalid, scl_lo, sda_lo, ack;
   int          failures = 0, checked = 0, cycles = 0;
   // open-drain wires with pull-up: released lines read high
   wire         scl = !(scl_lo || scl_oe);
   wire         sda = !(sda_lo || sda_oe);
   always #50 sys_clk = ~sys_clk;
   multi_function_i2c_slave #(.HALF_CYC(20)) i_dut (.sys_clk, .reset, .scl_in(scl), .scl_out,
      .scl_oe, .sda_in(sda), .sda_out, .sda_oe, .display_select_switch, .led_nibble,
      .led_upper_half, .adc_convert_start, .adc_channel, .adc_result_valid, .adc_result,
      .awvalid, .awready, .awaddr, .wvalid, .wready, .wdata, .wstrb, .bvalid, .bready, .bresp,
      .arvalid, .arready, .araddr, .rvalid, .rready, .rdata, .rresp);
   i2c_master_model i_mst (.scl, .sda, .scl_lo, .sda_lo);
   // converter stand-in answers each start one cycle later; also the hang limit
   always @(posedge sys_clk) begin
      adc_result_valid <= adc_convert_start;
      adc_result <= 12'h13C + {10'h000, adc_channel};
      cycles <= cycles + 1;
      if (cycles == 40000) begin
         failures++;
         complete_run();
      end
   end
   task axw(input logic [7:0] a, input logic [31:0] v);
      logic aw, w;
      @(posedge sys_clk);
      aw = 1;
      w = 1;
      awvalid <= 1;
      wvalid <= 1;
      awaddr <= a;
      wdata <= v;
      bready <= 1;
      while (aw || w) begin
         @(posedge sys_clk);
         if (awready === 1'b1) begin aw = 0; awvalid <= 0; end
         if (wready === 1'b1) begin w = 0; wvalid <= 0; end
      end
      while (bvalid !== 1'b1) @(posedge sys_clk);
      r = bresp;
      bready <= 0;
      @(posedge sys_clk);
   endtask : axw
   task axr(input logic [7:0] a);
      @(posedge sys_clk);
      arvalid <= 1;
      araddr <= a;
      rready <= 1;
      do @(posedge sys_clk); while (arready !== 1'b1);
      arvalid <= 0;
      while (rvalid !== 1'b1) @(posedge sys_clk);
      d = rdata;
      r = rresp;
      rready <= 0;
      @(posedge sys_clk);
   endtask : axr
   task t_regs;
      axr(`REG_CTRL);
      `CHK("ctrl", 32'h001E0003, d)
      axw(8'h0C, 32'h0);
      `CHK("bresp", 2'h2, r)
      axr(8'h0C);
      `CHK("rresp", 2'h2, r)
   endtask : t_regs
   task t_ram;
      i_mst.start();
      i_mst.send(8'h70, ack);
      `CHK("addr ack", 1'b1, ack)
      `CHK("latches", 2'h0, {scl_out, sda_out})
      i_mst.send(8'h7F, ack);
      i_mst.send(8'hA5, ack);
      i_mst.send(8'h5A, ack);
      `CHK("data ack", 1'b1, ack)
      i_mst.stop();
      axr(`REG_FLAGS);
      `CHK("flags", 2'h3, d[1:0])
      axr(`REG_STATUS);
      `CHK("id", `ID_RAM, d[7:4])
      i_mst.start();
      i_mst.send(8'h70, ack);
      i_mst.send(8'h7F, ack);
      i_mst.start();
      i_mst.send(8'h71, ack);
      i_mst.recv(1'b1, b);
      `CHK("ram 7f", 8'hA5, b)
      i_mst.recv(1'b0, b);
      `CHK("ram 00", 8'h5A, b)
      i_mst.stop();
   endtask : t_ram
   // unknown address, no edges, masked clock edges, ack disabled: all refused
   task sel_case(input logic [31:0] c, input logic [7:0] a);
      axw(`REG_CTRL, c);
      i_mst.start();
      i_mst.send(a, ack);
      `CHK("no ack", 1'b0, ack)
      i_mst.stop();
   endtask : sel_case
   task t_sel;
      sel_case(32'h001E0003, 8'hA0);
      sel_case(32'h001E0000, 8'h70);
      sel_case(32'h001E0007, 8'h70);
      axr(`REG_FLAGS);
      `CHK("scl request", 1'b1, d[2])
      axw(`REG_FLAGS, 32'h00000004);
      axr(`REG_FLAGS);
      `CHK("request cleared", 1'b0, d[2])
      sel_case(32'h001A0003, 8'h70);
      axw(`REG_CTRL, `CTRL_RESET);
   endtask : t_sel
   task led(input logic [7:0] v);
      repeat (45) @(posedge sys_clk);
      @(posedge led_upper_half);
      repeat (2) @(posedge sys_clk);
      `CHK("upper", v[7:4], led_nibble)
      @(negedge led_upper_half);
      repeat (2) @(posedge sys_clk);
      `CHK("lower", v[3:0], led_nibble)
   endtask : led
   task t_disp;
      i_mst.start();
      i_mst.send(8'h60, ack);
      i_mst.send(8'h00, ack);
      i_mst.send(8'h3C, ack);
      i_mst.send(8'hC3, ack);
      repeat (60) @(posedge sys_clk);
      `CHK("uncommitted", 4'h0, led_nibble)
      i_mst.stop();
      led(8'h3C);
      display_select_switch <= 1;
      led(8'hC3);
   endtask : t_disp
   // constant samples per channel make every average equal to its sample
   task t_adc;
      repeat (12000) @(posedge sys_clk);
      i_mst.start();
      i_mst.send(8'h61, ack);
      for (int c = 0; c < 4; c++) begin
         i_mst.recv(1'b1, b);
         `CHK("adc hi", 8'h01, b)
         i_mst.recv(c < 3, b);
         `CHK("adc lo", 8'h3C + 8'(c), b)
      end
      i_mst.stop();
   endtask : t_adc
   task complete_run;
      $display("checked %0d failures %0d", checked, failures);
      if (failures == 0 && checked > 0) $display("All tests passed");
      else $display("Some tests failed");
      $finish;
   endtask : complete_run
   initial begin
      repeat (16) @(posedge sys_clk);
      reset <= 0;
      repeat (4) @(posedge sys_clk);
      t_regs();
      t_ram();
      t_sel();
      t_disp();
      t_adc();
      complete_run();
   end
endmodule : tb
